// ==== design/acc_rule_map.svh ====
// register offsets, field positions, reset values and tag codes of the access rule evaluator
`ifndef ACC_RULE_MAP_SVH
`define ACC_RULE_MAP_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFS_CTRL     12'h000
`define OFS_CMD      12'h004
`define OFS_COND     12'h008
`define OFS_KEYS     12'h00c
`define OFS_RDATA    12'h010
`define OFS_STATUS   12'h014
`define OFS_REF      12'h018

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CTRL_START   0
`define CTRL_CLR     1
`define ST_BUSY      0
`define ST_ALLOW     1
`define ST_ERR       2
`define ST_REF       3
`define REF_EXPL     24

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_GRP      3'h0
`define RST_INS      8'h00
`define RST_CTX      4'h0
`define RST_TMPL     2'h0
`define RST_COND     4'h0
`define RST_KEYS     32'h0000_0000

// ----------------------------------------------------------------------
// object tags and special condition bytes
// ----------------------------------------------------------------------
`define TAG_COMPACT  8'h8c
`define TAG_EXPAND   8'hab
`define TAG_REF      8'h8b
`define TAG_MODE     8'h80
`define TAG_SMDESC   8'h9c
`define TAG_GRANT    8'h90
`define TAG_DENY     8'h97
`define TAG_AUTH     8'ha4
`define TAG_OR       8'ha0
`define TAG_AND      8'haf
`define TAG_KEYREF   8'h83
`define CB_GRANT     8'h00
`define CB_DENY      8'hff

`endif

// ==== design/acc_rule_pkg.sv ====
// types shared by the access rule evaluator
package acc_rule_pkg;
    typedef enum logic [5:0] {
        st_idle    = 6'b000001,
        st_head    = 6'b000010,
        st_compact = 6'b000100,
        st_exp     = 6'b001000,
        st_ref     = 6'b010000,
        st_done    = 6'b100000
    } eval_state_t;
endpackage

// ==== design/access_rule_evaluator.sv ====
// access rule evaluator: apb register file, rule buffer and rule walker
`timescale 1ns/1ps
`include "acc_rule_map.svh"
module access_rule_evaluator #(
    parameter int BUF_DEPTH = 64
) (
    // clock and reset
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // apb slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // verdict
    output logic                           allow,
    output logic                           done,
    output logic                           busy,
    output acc_rule_pkg::eval_state_t      eval_state
);
    import acc_rule_pkg::*;

    localparam int AW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

    // ----------------------------------------------------------------------
    // state
    // ----------------------------------------------------------------------
    eval_state_t  st_q, st_d;
    logic [7:0]   mem [BUF_DEPTH];
    logic [7:0]   cnt_q;
    logic [2:0]   grp_q;
    logic [7:0]   ins_q;
    logic [3:0]   ctx_q;
    logic [1:0]   tmpl_q;
    logic [3:0]   cond_q;
    logic [31:0]  keys_q;
    logic [7:0]   ptr_q, ptr_d, end_q, end_d, tend_q, tend_d;
    logic         grant_q, grant_d, err_q, err_d;
    logic         open_q, open_d, appl_q, appl_d, acc_q, acc_d, have_q, have_d;
    logic         intpl_q, intpl_d, tor_q, tor_d, tacc_q, tacc_d;
    logic         ref_ok_q, ref_ok_d, ref_ext_q, ref_ext_d;
    logic [7:0]   ref_rec_q, ref_rec_d;
    logic [15:0]  ref_fid_q, ref_fid_d;
    logic         pready_q, pslverr_q, allow_q, done_q, busy_q;
    logic [31:0]  prdata_q, rdmux;
    logic         acc_en, wr, hit, start;

    function automatic logic [7:0] rb(input logic [7:0] i);
        rb = ({24'h0, i} < BUF_DEPTH) ? mem[i[AW-1:0]] : 8'h00;
    endfunction

    // ----------------------------------------------------------------------
    // apb slave: one wait state so read data leaves a flop
    // ----------------------------------------------------------------------
    assign acc_en = psel & penable & pready_q;
    assign wr     = acc_en & pwrite;
    assign start  = wr && paddr == `OFS_CTRL && pwdata[`CTRL_START] && st_q == st_idle;

    always_comb begin
        hit   = 1'b1;
        rdmux = 32'h0;
        case (paddr)
            `OFS_CTRL:   rdmux = 32'h0;
            `OFS_CMD:    rdmux = {10'h0, tmpl_q, ctx_q, ins_q, 5'h0, grp_q};
            `OFS_COND:   rdmux = {28'h0, cond_q};
            `OFS_KEYS:   rdmux = keys_q;
            `OFS_RDATA:  rdmux = {24'h0, cnt_q};
            `OFS_STATUS: rdmux = {28'h0, ref_ok_q, err_q, allow_q, busy_q};
            `OFS_REF:    rdmux = {7'h0, ref_ext_q, ref_fid_q, ref_rec_q};
            default:     hit   = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= psel & penable & ~pready_q;
            if (psel & penable & ~pready_q) begin
                prdata_q  <= pwrite ? 32'h0 : rdmux;
                pslverr_q <= ~hit;
            end
        end
    end

    // command group, context, satisfied conditions, verified keys
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            grp_q  <= `RST_GRP;
            ins_q  <= `RST_INS;
            ctx_q  <= `RST_CTX;
            tmpl_q <= `RST_TMPL;
            cond_q <= `RST_COND;
            keys_q <= `RST_KEYS;
        end else if (wr && st_q == st_idle) begin
            case (paddr)
                `OFS_CMD: begin
                    grp_q  <= (pwdata[2:0] == 3'h7) ? 3'h6 : pwdata[2:0];
                    ins_q  <= pwdata[15:8];
                    ctx_q  <= pwdata[19:16];
                    tmpl_q <= pwdata[21:20];
                end
                `OFS_COND: cond_q <= pwdata[3:0];
                `OFS_KEYS: keys_q <= pwdata;
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------------
    // rule byte buffer; loads are ignored while a walk runs
    // ----------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 8'h00;
        end else if (wr && st_q == st_idle) begin
            if (paddr == `OFS_CTRL && pwdata[`CTRL_CLR]) begin
                cnt_q <= 8'h00;
            end else if (paddr == `OFS_RDATA && {24'h0, cnt_q} < BUF_DEPTH) begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end

    always_ff @(posedge pclk) begin
        if (wr && st_q == st_idle && paddr == `OFS_RDATA && {24'h0, cnt_q} < BUF_DEPTH) begin
            mem[cnt_q[AW-1:0]] <= pwdata[7:0];
        end
    end

    // ----------------------------------------------------------------------
    // walker decode
    // ----------------------------------------------------------------------
    logic [7:0] b0, b1, b2, b4, nxt, cm_sc, ex_ins;
    logic [6:0] cm_mask;
    logic [2:0] cm_n, cm_above, cm_sat, fl;
    logic [1:0] need;
    logic [7:0] cm_after;
    logic       cm_term, cb_pass, ctx_ok, sm_ok, ex_term, is_mode, mode_ap, set_ok;

    assign b0  = rb(ptr_q);
    assign b1  = rb(ptr_q + 8'd1);
    assign b2  = rb(ptr_q + 8'd2);
    assign b4  = rb(ptr_q + 8'd4);
    assign nxt = ptr_q + 8'd2 + b1;

    always_comb begin
        cm_mask  = b0[7] ? {4'h0, b0[2:0]} : b0[6:0];
        cm_n     = 3'($countones(cm_mask));
        cm_above = 3'($countones(cm_mask & ~((7'h02 << grp_q) - 7'h01)));
        cm_sc    = rb(ptr_q + 8'd1 + {5'h0, cm_above});
        cm_after = ptr_q + 8'd1 + {5'h0, cm_n};
        ctx_ok   = cm_sc[3:0] == 4'h0 || cm_sc[3:0] == ctx_q;
        need     = (cm_sc[3:0] == 4'h0) ? 2'b11 : tmpl_q;
        sm_ok    = (need & ~cond_q[3:2]) == 2'b00;
        cm_sat   = {sm_ok, cond_q[1], cond_q[0]} & {3{ctx_ok}};
        fl       = cm_sc[6:4];
        if (cm_sc == `CB_GRANT) begin
            cb_pass = 1'b1;
        end else if (cm_sc == `CB_DENY || fl == 3'h0) begin
            cb_pass = 1'b0;
        end else if (cm_sc[7]) begin
            cb_pass = (fl & ~cm_sat) == 3'h0;
        end else begin
            cb_pass = |(fl & cm_sat);
        end
        cm_term  = cm_mask[grp_q] && cb_pass;
        ex_ins   = rb(ptr_q + 8'd2 + {7'h00, b0[3]});
        is_mode  = b0[7:4] == 4'h8 || b0 == `TAG_SMDESC;
        if (b0 == `TAG_MODE) begin
            mode_ap = b1 == 8'h01 && (b2[7] ? (grp_q < 3'd3 && b2[grp_q]) : b2[grp_q]);
        end else if (b0 == `TAG_SMDESC) begin
            mode_ap = 1'b0;
        end else begin
            mode_ap = b0[2] && ex_ins == ins_q;
        end
        if (b0 == `TAG_GRANT) begin
            ex_term = 1'b1;
        end else if (b0 == `TAG_AUTH) begin
            ex_term = b2 == `TAG_KEYREF && keys_q[{b4[7], b4[3:0]}];
        end else begin
            ex_term = 1'b0;
        end
        set_ok = open_q & appl_q & have_q & acc_q;
    end

    // ----------------------------------------------------------------------
    // walker next state
    // ----------------------------------------------------------------------
    always_comb begin
        st_d = st_q; ptr_d = ptr_q; end_d = end_q; tend_d = tend_q;
        grant_d = grant_q; err_d = err_q; open_d = open_q; appl_d = appl_q;
        acc_d = acc_q; have_d = have_q; intpl_d = intpl_q; tor_d = tor_q;
        tacc_d = tacc_q; ref_ok_d = ref_ok_q; ref_ext_d = ref_ext_q;
        ref_rec_d = ref_rec_q; ref_fid_d = ref_fid_q;
        case (st_q)
            st_idle: begin
                if (start) begin
                    st_d = st_head; ptr_d = 8'h00; grant_d = 1'b0; err_d = 1'b0;
                    open_d = 1'b0; intpl_d = 1'b0; ref_ok_d = 1'b0;
                end
            end
            st_head: begin
                end_d = nxt;
                ptr_d = 8'd2;
                if (nxt > cnt_q || b1 == 8'h00) begin
                    err_d = 1'b1; st_d = st_done;
                end else if (b0 == `TAG_COMPACT) begin
                    st_d = st_compact;
                end else if (b0 == `TAG_EXPAND) begin
                    st_d = st_exp;
                end else if (b0 == `TAG_REF) begin
                    st_d = st_done;
                    if (b1 == 8'h01) begin
                        ref_ok_d = 1'b1; ref_ext_d = 1'b0; ref_rec_d = b2;
                        ref_fid_d = 16'h0000;
                    end else if (b1 == 8'h03) begin
                        ref_ok_d = 1'b1; ref_ext_d = 1'b1; ref_rec_d = b4;
                        ref_fid_d = {b2, rb(8'd3)};
                    end else if (b1 >= 8'h04 && !b1[0]) begin
                        st_d = st_ref;
                    end else begin
                        err_d = 1'b1;
                    end
                end else begin
                    err_d = 1'b1; st_d = st_done;
                end
            end
            st_compact: begin
                if (cm_after > end_q) begin
                    err_d = 1'b1; st_d = st_done;
                end else begin
                    grant_d = grant_q | cm_term;
                    ptr_d   = cm_after;
                    if (cm_after >= end_q) st_d = st_done;
                end
            end
            st_exp: begin
                if (intpl_q && ptr_q >= tend_q) begin
                    acc_d = acc_q & tacc_q; intpl_d = 1'b0;
                end else if (ptr_q >= end_q) begin
                    grant_d = grant_q | set_ok; st_d = st_done;
                end else if (nxt > end_q) begin
                    err_d = 1'b1; st_d = st_done;
                end else if (is_mode) begin
                    grant_d = grant_q | set_ok;
                    open_d = 1'b1; appl_d = mode_ap; acc_d = 1'b1; have_d = 1'b0;
                    ptr_d = nxt;
                end else if (b0 == `TAG_OR || b0 == `TAG_AND) begin
                    intpl_d = 1'b1; tor_d = b0 == `TAG_OR; tacc_d = b0 != `TAG_OR;
                    tend_d = nxt; have_d = 1'b1; ptr_d = ptr_q + 8'd2;
                end else begin
                    if (intpl_q && tor_q) begin
                        tacc_d = tacc_q | ex_term;
                    end else if (intpl_q) begin
                        tacc_d = tacc_q & ex_term;
                    end else begin
                        acc_d = acc_q & ex_term;
                    end
                    have_d = 1'b1; ptr_d = nxt;
                end
            end
            st_ref: begin
                if (b0 == {4'h0, ctx_q}) begin
                    ref_ok_d = 1'b1; ref_ext_d = 1'b0; ref_rec_d = b1;
                    ref_fid_d = 16'h0000; st_d = st_done;
                end else begin
                    ptr_d = ptr_q + 8'd2;
                    if (ptr_q + 8'd2 >= end_q) st_d = st_done;
                end
            end
            st_done: st_d = st_idle;
            default: st_d = st_idle;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= st_idle; ptr_q <= 8'h00; end_q <= 8'h00; tend_q <= 8'h00;
            grant_q <= 1'b0; err_q <= 1'b0; open_q <= 1'b0; appl_q <= 1'b0;
            acc_q <= 1'b0; have_q <= 1'b0; intpl_q <= 1'b0; tor_q <= 1'b0;
            tacc_q <= 1'b0; ref_ok_q <= 1'b0; ref_ext_q <= 1'b0;
            ref_rec_q <= 8'h00; ref_fid_q <= 16'h0000;
        end else begin
            st_q <= st_d; ptr_q <= ptr_d; end_q <= end_d; tend_q <= tend_d;
            grant_q <= grant_d; err_q <= err_d; open_q <= open_d; appl_q <= appl_d;
            acc_q <= acc_d; have_q <= have_d; intpl_q <= intpl_d; tor_q <= tor_d;
            tacc_q <= tacc_d; ref_ok_q <= ref_ok_d; ref_ext_q <= ref_ext_d;
            ref_rec_q <= ref_rec_d; ref_fid_q <= ref_fid_d;
        end
    end

    // ----------------------------------------------------------------------
    // verdict outputs; a reference gives deny until the record is loaded
    // ----------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            allow_q <= 1'b0;
            done_q  <= 1'b0;
            busy_q  <= 1'b0;
        end else begin
            done_q <= st_q == st_done;
            busy_q <= st_d != st_idle;
            if (st_q == st_done) allow_q <= grant_q & ~err_q;
        end
    end

    assign prdata     = prdata_q;
    assign pready     = pready_q;
    assign pslverr    = pslverr_q;
    assign allow      = allow_q;
    assign done       = done_q;
    assign busy       = busy_q;
    assign eval_state = st_q;

    // ----------------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------------
    property p_done_pulse;
        @(posedge pclk) disable iff (!presetn) done_q |=> !done_q;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
    property p_verdict;
        @(posedge pclk) disable iff (!presetn)
            st_q == st_done |=> done_q && allow_q == $past(grant_q && !err_q);
    endproperty
    a_verdict: assert property (p_verdict) else $error("verdict not tied to walk");
    property p_unset_denies;
        @(posedge pclk) disable iff (!presetn)
            st_q == st_compact && !cm_mask[grp_q] |=> grant_q == $past(grant_q);
    endproperty
    a_unset_denies: assert property (p_unset_denies) else $error("unset group granted");
    property p_count;
        @(posedge pclk) disable iff (!presetn)
            st_q == st_compact && !b0[7] && cm_after <= end_q |=>
            ptr_q == $past(ptr_q) + 8'd1 + 8'($countones($past(b0[6:0])));
    endproperty
    a_count: assert property (p_count) else $error("condition count wrong");
    property p_all;
        @(posedge pclk) disable iff (!presetn)
            st_q == st_compact && cm_sc[7] && cm_sc != `CB_DENY && cb_pass |->
            (cm_sc[6:4] & ~cm_sat) == 3'h0;
    endproperty
    a_all: assert property (p_all) else $error("all-of condition passed short");
    property p_any;
        @(posedge pclk) disable iff (!presetn)
            st_q == st_compact && !cm_sc[7] && cm_sc != `CB_GRANT && cb_pass |->
            (cm_sc[6:4] & cm_sat) != 3'h0;
    endproperty
    a_any: assert property (p_any) else $error("any-of condition passed empty");
    property p_or_sets;
        @(posedge pclk) disable iff (!presetn)
            st_q == st_compact && grant_q |=> grant_q;
    endproperty
    a_or_sets: assert property (p_or_sets) else $error("granted set lost");
    property p_short_ref;
        @(posedge pclk) disable iff (!presetn)
            st_q == st_head && b0 == `TAG_REF && b1 == 8'h01 && nxt <= cnt_q |->
            ##2 (ref_ok_q && !ref_ext_q && ref_rec_q == $past(b2, 2));
    endproperty
    a_short_ref: assert property (p_short_ref) else $error("one byte reference lost");
    property p_and_fail;
        @(posedge pclk) disable iff (!presetn)
            st_q == st_exp && st_d == st_exp && !is_mode && b0 != `TAG_OR && b0 != `TAG_AND
            && !intpl_q && ptr_q < end_q && nxt <= end_q && !ex_term |=> !acc_q;
    endproperty
    a_and_fail: assert property (p_and_fail) else $error("failed condition ignored");
    property p_or_pass;
        @(posedge pclk) disable iff (!presetn)
            st_q == st_exp && intpl_q && tor_q && ptr_q < tend_q && nxt <= end_q
            && !is_mode && ex_term |=> tacc_q;
    endproperty
    a_or_pass: assert property (p_or_pass) else $error("or template missed pass");
endmodule

// ==== test/rule_host.sv ====
// card command handler model: apb master that loads rules and starts walks
`timescale 1ns/1ps
`include "acc_rule_map.svh"
module rule_host (
    // clock
    input  wire logic        pclk,
    // apb master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
    end

    // request held until pready is seen high, released only after that edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        xfer(1'b1, a, d, r, e);
    endtask

    // one rule byte per write, then command, conditions and start
    task automatic load(input logic [7:0] b[$], input logic [31:0] cmd, input logic [3:0] c);
        wr(`OFS_CTRL, 32'h0000_0002);
        foreach (b[i]) wr(`OFS_RDATA, {24'h0, b[i]});
        wr(`OFS_CMD, cmd);
        wr(`OFS_COND, {28'h0, c});
        wr(`OFS_CTRL, 32'h0000_0001);
    endtask
endmodule

// ==== test/tb.sv ====
// self-checking bench for the access rule evaluator
`timescale 1ns/1ps
`include "acc_rule_map.svh"
module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, allow, done, busy, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, rnd;
    acc_rule_pkg::eval_state_t eval_state;
    logic [7:0] rb[$];
    logic       expq[$];
    int         bad_count = 0;
    int         checked = 0;

    access_rule_evaluator dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .allow(allow), .done(done), .busy(busy), .eval_state(eval_state));
    rule_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial pclk = 1'b0;
    always #50 pclk = ~pclk;

    task automatic complete_run();
        if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    // verdicts are noted by the driver and taken off when done pulses
    always @(posedge pclk) begin
        if (done === 1'b1) begin
            if (expq.size() == 0) chk_word(32'h0, 32'h1);
            else chk_word({31'h0, expq.pop_front()}, {31'h0, allow});
        end
    end

    task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        host.xfer(1'b0, a, 32'h0, rd, err);
        chk_word(e, rd & m);
    endtask

    // a missing done pulse leaves the note queued and shows up here
    task automatic run(input logic [31:0] cmd, input logic [3:0] c, input logic e);
        int n;
        expq.push_back(e);
        host.load(rb, cmd, c);
        @(posedge pclk);
        chk_word(32'h1, {31'h0, busy});
        n = 0;
        while (expq.size() != 0 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        chk_word(32'h0, expq.size());
        chk_word(32'h0, {31'h0, busy});
        chk_word({26'h0, acc_rule_pkg::st_idle}, {26'h0, eval_state});
        expq.delete();
    endtask

    initial begin
        presetn = 1'b0;
        rnd = $urandom(32'h4581);
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(`OFS_CMD, 32'hffff_ffff, 32'h0);
        host.xfer(1'b0, 12'h0fc, 32'h0, rd, err);
        chk_word(32'h1, {31'h0, err});
        rnd = $urandom();
        host.wr(`OFS_KEYS, rnd);
        rdchk(`OFS_KEYS, 32'hffff_ffff, rnd);
        rb = '{8'h8c, 8'h02, 8'h01, 8'h00};
        run(32'h0, 4'h0, 1'b1);
        run(32'h1, 4'h0, 1'b0);
        rb = '{8'h8c, 8'h03, 8'h03, 8'h00, 8'hff};
        run(32'h0, 4'h0, 1'b0);
        run(32'h1, 4'h0, 1'b1);
        rb = '{8'h8c, 8'h04, 8'h01, 8'hff, 8'h01, 8'h00};
        run(32'h0, 4'h0, 1'b1);
        rb = '{8'h8c, 8'h02, 8'h81, 8'h00};
        run(32'h6, 4'h0, 1'b0);
        rb = '{8'h8c, 8'h02, 8'h01, 8'h90};
        run(32'h0, 4'h0, 1'b0);
        run(32'h0, 4'h1, 1'b1);
        rb = '{8'h8c, 8'h02, 8'h01, 8'h60};
        run(32'h0, 4'h2, 1'b1);
        rb = '{8'h8c, 8'h02, 8'h01, 8'he0};
        run(32'h0, 4'h3, 1'b0);
        run(32'h0, 4'hf, 1'b1);
        rb = '{8'h8c, 8'h02, 8'h01, 8'h91};
        run(32'h0, 4'h1, 1'b0);
        run(32'h0001_0000, 4'h1, 1'b1);
        rb = '{8'h8c, 8'h00};
        run(32'h0, 4'h0, 1'b0);
        rdchk(`OFS_STATUS, 32'h0000_000f, 32'h0000_0004);
        rb = '{8'hab, 8'h0b, 8'h80, 8'h01, 8'h01, 8'ha4, 8'h06, 8'h83, 8'h01, 8'h01, 8'h95,
               8'h01, 8'h08};
        run(32'h0, 4'h0, rnd[1]);
        host.wr(`OFS_KEYS, ~rnd);
        run(32'h0, 4'h0, ~rnd[1]);
        rb = '{8'hab, 8'h05, 8'h80, 8'h01, 8'h01, 8'h90, 8'h00};
        run(32'h0, 4'h0, 1'b1);
        rb = '{8'hab, 8'h09, 8'h80, 8'h01, 8'h01, 8'ha0, 8'h04, 8'h97, 8'h00, 8'h90, 8'h00};
        run(32'h0, 4'h0, 1'b1);
        rb[5] = 8'haf;
        run(32'h0, 4'h0, 1'b0);
        rb = '{8'hab, 8'h07, 8'h80, 8'h01, 8'h01, 8'h90, 8'h00, 8'h97, 8'h00};
        run(32'h0, 4'h0, 1'b0);
        rb = '{8'hab, 8'h0a, 8'h80, 8'h01, 8'h01, 8'h97, 8'h00, 8'h80, 8'h01, 8'h01, 8'h90, 8'h00};
        run(32'h0, 4'h0, 1'b1);
        rb = '{8'hab, 8'h05, 8'h84, 8'h01, 8'hb0, 8'h90, 8'h00};
        run(32'h0000_b000, 4'h0, 1'b1);
        rb[2] = 8'h9c;
        run(32'h0000_b000, 4'h0, 1'b0);
        rb = '{8'h8b, 8'h01, 8'h05};
        run(32'h0, 4'h0, 1'b0);
        rdchk(`OFS_REF, 32'hffff_ffff, 32'h0000_0005);
        rb = '{8'h8b, 8'h03, 8'h2f, 8'h06, 8'h02};
        run(32'h0, 4'h0, 1'b0);
        rdchk(`OFS_REF, 32'hffff_ffff, 32'h012f_0602);
        rb = '{8'h8b, 8'h04, 8'h01, 8'h07, 8'h02, 8'h09};
        run(32'h0002_0000, 4'h0, 1'b0);
        rdchk(`OFS_REF, 32'h0000_00ff, 32'h0000_0009);
        complete_run();
    end

    // ceiling well above the thousand or so cycles the sequence needs
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        complete_run();
    end
endmodule
